// File: logic/fdc_pkg.sv
// Constants for the FSK deviation and receive-termination configuration block.
// Assumes one 25 MHz clock domain and a synchronous, active-high reset.
package fdc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [5:0] FDC_DEV_OFFSET   = 6'h15;
  localparam logic [5:0] FDC_SMC2_OFFSET  = 6'h16;
  // ==========================================================================
  // Field positions and reset values
  localparam int         FDC_DEV_E_LSB    = 4;
  localparam int         FDC_DEV_M_LSB    = 0;
  localparam int         FDC_TERM_BIT     = 4;
  localparam int         FDC_TUNE_LSB     = 0;
  localparam logic [2:0] FDC_DEV_E_RST    = 3'h4;
  localparam logic [2:0] FDC_DEV_M_RST    = 3'h7;
  localparam logic       FDC_TERM_RST     = 1'b0;
  localparam logic [3:0] FDC_TUNE_RST     = 4'h7;
  // ==========================================================================
  // Arithmetic and timing
  localparam logic [3:0] FDC_IMPLIED_ONE  = 4'h8;
  localparam int         FDC_DEV_W        = 11;
  localparam logic [3:0] FDC_OOK_CS_SYMS  = 4'h8;
  typedef enum logic [1:0] {FDC_IDLE, FDC_WAIT_CS, FDC_HOLD, FDC_DONE} fdc_rx_state_t;
endpackage

// File: logic/fdc_dev_if.sv
// Carries deviation fields to the calculator and the deviation word back.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/10ps
`default_nettype none
interface fdc_dev_if;
  import fdc_pkg::*;
  logic [2:0]          dev_exp;
  logic [2:0]          dev_man;
  logic                ook;
  logic [FDC_DEV_W-1:0] dev_word;
  modport calc (input dev_exp, input dev_man, input ook, output dev_word);
  modport cfg  (output dev_exp, output dev_man, output ook, input dev_word);
endinterface
`default_nettype wire

// File: logic/fdc_dev_calc.sv
// Deviation word from exponent and mantissa, in units of crystal / 2^17.
// Assumes fields come straight from the configuration register.
`timescale 1ns/10ps
`default_nettype none
module fdc_dev_calc
  import fdc_pkg::*;
(
  fdc_dev_if.calc dev
);
  // ==========================================================================
  // Mantissa with implied leading one, shifted by exponent
  function automatic logic [FDC_DEV_W-1:0] dev_of(input logic [2:0] e, input logic [2:0] m);
    logic [FDC_DEV_W-1:0] base;
    base   = {{(FDC_DEV_W-4){1'b0}}, FDC_IMPLIED_ONE | {1'b0, m}};
    dev_of = base << e;
  endfunction

  // OOK has no deviation at all
  assign dev.dev_word = dev.ook ? '0 : dev_of(dev.dev_exp, dev.dev_man); // [R3] [R6]
endmodule
`default_nettype wire

// File: logic/fdc_top.sv
// FSK deviation setting and carrier-sense receive termination configuration.
// Assumes a plain register port at printed offsets and a modem that gives
// symbol ticks, carrier sense and receive/transmit activity levels.
//
// Contract
// [R1] Deviation exponent in bits 6:4, read-write, resets to 4.
// [R2] Deviation mantissa in bits 2:0, read-write, resets to 7.
// [R3] Deviation is crystal/2^17 times (8 plus mantissa) times 2^exponent.
// [R4] FSK transmit shifts carrier down for zero, up for one.
// [R5] FSK receive uses the configured deviation as expected deviation.
// [R6] OOK ignores exponent and mantissa in receive and transmit.
// [R7] Receive-termination bit 4, read-write, resets 0, ends receive on carrier sense.
// [R8] OOK with termination times out without carrier sense in first 8 symbols.
// [R9] Tuning field bits 3:0, read-write, resets to 0111.
// [R10] Unused bits read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
module fdc_top
  import fdc_pkg::*;
(
  input  wire logic                  CLK_I,
  input  wire logic                  RST_I,
  input  wire logic [5:0]            REG_ADDR_I,
  input  wire logic                  REG_WE_I,
  input  wire logic                  REG_RE_I,
  input  wire logic [7:0]            REG_WDATA_I,
  output logic      [7:0]            REG_RDATA_O,
  input  wire logic                  MOD_OOK_I,
  input  wire logic                  TX_ACTIVE_I,
  input  wire logic                  TX_SYMBOL_I,
  output logic signed [FDC_DEV_W:0]  TX_FREQ_OFFSET_O,
  input  wire logic                  RX_ACTIVE_I,
  input  wire logic                  SYMBOL_TICK_I,
  input  wire logic                  CARRIER_SENSE_I,
  output logic      [FDC_DEV_W-1:0]  RX_EXPECTED_DEV_O,
  output logic                       RX_TERMINATE_O,
  output logic      [3:0]            TUNE_O
);
  logic [2:0]    dev_e_q;
  logic [2:0]    dev_m_q;
  logic          term_en_q;
  logic [3:0]    tune_q;
  logic [3:0]    sym_cnt_q;
  fdc_rx_state_t state_q;

  fdc_dev_if dev_bus ();

  assign dev_bus.dev_exp = dev_e_q;
  assign dev_bus.dev_man = dev_m_q;
  assign dev_bus.ook     = MOD_OOK_I;

  fdc_dev_calc u_calc (
    .dev (dev_bus.calc)
  );

  // ==========================================================================
  // Register writes
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      dev_e_q   <= FDC_DEV_E_RST;                                  // [R1]
      dev_m_q   <= FDC_DEV_M_RST;                                  // [R2]
      term_en_q <= FDC_TERM_RST;                                   // [R7]
      tune_q    <= FDC_TUNE_RST;                                   // [R9]
    end else if (REG_WE_I) begin
      if (REG_ADDR_I == FDC_DEV_OFFSET) begin
        dev_e_q <= REG_WDATA_I[FDC_DEV_E_LSB +: 3];                 // [R1]
        dev_m_q <= REG_WDATA_I[FDC_DEV_M_LSB +: 3];                 // [R2] [R10]
      end else if (REG_ADDR_I == FDC_SMC2_OFFSET) begin
        term_en_q <= REG_WDATA_I[FDC_TERM_BIT];                    // [R7]
        tune_q    <= REG_WDATA_I[FDC_TUNE_LSB +: 4];               // [R9] [R10]
      end
    end
  end

  // ==========================================================================
  // Register reads, one cycle after the read strobe
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RE_I) begin
      if (REG_ADDR_I == FDC_DEV_OFFSET) begin
        REG_RDATA_O <= {1'b0, dev_e_q, 1'b0, dev_m_q};             // [R1] [R2] [R10]
      end else if (REG_ADDR_I == FDC_SMC2_OFFSET) begin
        REG_RDATA_O <= {3'h0, term_en_q, tune_q};                  // [R7] [R9] [R10]
      end else begin
        REG_RDATA_O <= 8'h00;
      end
    end
  end

  assign TUNE_O = tune_q;

  // ==========================================================================
  // Transmit tone offset; zero under OOK or when not sending
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      TX_FREQ_OFFSET_O <= '0;
    end else if (!TX_ACTIVE_I || MOD_OOK_I) begin
      TX_FREQ_OFFSET_O <= '0;                                      // [R6]
    end else if (TX_SYMBOL_I) begin
      TX_FREQ_OFFSET_O <= $signed({1'b0, dev_bus.dev_word});       // [R4]
    end else begin
      TX_FREQ_OFFSET_O <= -$signed({1'b0, dev_bus.dev_word});      // [R4]
    end
  end

  // ==========================================================================
  // Expected receive deviation for the demodulator
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RX_EXPECTED_DEV_O <= '0;
    end else begin
      RX_EXPECTED_DEV_O <= dev_bus.dev_word;                       // [R5] [R6]
    end
  end

  // ==========================================================================
  // Carrier-sense termination. OOK: give up if no carrier sense within the
  // first symbols. FSK: end once carrier sense, having been seen, drops.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_q        <= FDC_IDLE;
      sym_cnt_q      <= 4'h0;
      RX_TERMINATE_O <= 1'b0;
    end else begin
      RX_TERMINATE_O <= 1'b0;
      if (!RX_ACTIVE_I) begin
        state_q <= FDC_IDLE;
      end else begin
        case (state_q)
          FDC_IDLE: begin
            sym_cnt_q <= 4'h0;
            if (term_en_q) begin
              state_q <= FDC_WAIT_CS;                              // [R7]
            end
          end
          FDC_WAIT_CS: begin
            if (CARRIER_SENSE_I) begin
              state_q <= FDC_HOLD;
            end else if (SYMBOL_TICK_I) begin
              sym_cnt_q <= sym_cnt_q + 4'h1;
              if (MOD_OOK_I && (sym_cnt_q + 4'h1 == FDC_OOK_CS_SYMS)) begin
                RX_TERMINATE_O <= 1'b1;                            // [R8]
                state_q        <= FDC_DONE;
              end
            end
          end
          FDC_HOLD: begin
            if (!MOD_OOK_I && !CARRIER_SENSE_I) begin
              RX_TERMINATE_O <= 1'b1;                              // [R7]
              state_q        <= FDC_DONE;
            end
          end
          default: begin
            state_q <= FDC_DONE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/fdc_top_asserts.sv
// Port checks for the deviation and receive-termination block.
// Assumes one clock domain and the bind below.
`timescale 1ns/10ps
`default_nettype none
module fdc_top_asserts
  import fdc_pkg::*;
(
  input wire logic              CLK_I,
  input wire logic              RST_I,
  input wire logic [5:0]        REG_ADDR_I,
  input wire logic              REG_RE_I,
  input wire logic [7:0]        REG_RDATA_O,
  input wire logic              MOD_OOK_I,
  input wire logic              TX_ACTIVE_I,
  input wire logic              TX_SYMBOL_I,
  input wire logic signed [FDC_DEV_W:0] TX_FREQ_OFFSET_O,
  input wire logic              RX_ACTIVE_I,
  input wire logic              CARRIER_SENSE_I,
  input wire logic [FDC_DEV_W-1:0] RX_EXPECTED_DEV_O,
  input wire logic              RX_TERMINATE_O
);
  // ==========
  // Offset magnitude must track the receive word
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire logic [11:0] dev_s = {1'b0, RX_EXPECTED_DEV_O};
  chk_tx_offset: assert property (TX_ACTIVE_I && !MOD_OOK_I |=>
    TX_FREQ_OFFSET_O == ($past(TX_SYMBOL_I) ? dev_s : -dev_s)) else $error("tx offset");
  chk_tx_quiet: assert property (MOD_OOK_I || !TX_ACTIVE_I |=>
    TX_FREQ_OFFSET_O == 12'h000) else $error("tx offset not zero");
  chk_term_single: assert property (RX_TERMINATE_O |=> !RX_TERMINATE_O)
    else $error("end pulse too long");
  chk_term_idle: assert property (!RX_ACTIVE_I ##1 !RX_ACTIVE_I |=> !RX_TERMINATE_O)
    else $error("end pulse while idle");
  chk_term_cs_low: assert property (RX_TERMINATE_O |-> !$past(CARRIER_SENSE_I))
    else $error("end pulse with carrier");
  chk_rd_hold: assert property (!REG_RE_I |=> $stable(REG_RDATA_O))
    else $error("read data moved");
  chk_dev_unused: assert property (REG_RE_I && REG_ADDR_I == FDC_DEV_OFFSET |=>
    REG_RDATA_O[7] == 1'b0 && REG_RDATA_O[3] == 1'b0) else $error("unused bit set");
  chk_unmapped_zero: assert property (REG_RE_I && REG_ADDR_I != FDC_DEV_OFFSET &&
    REG_ADDR_I != FDC_SMC2_OFFSET |=> REG_RDATA_O == 8'h00) else $error("unmapped read");
  cover property (RX_TERMINATE_O && MOD_OOK_I);
  cover property (TX_ACTIVE_I && TX_SYMBOL_I && !MOD_OOK_I);
  cover property (REG_RE_I && REG_ADDR_I == FDC_SMC2_OFFSET);
  cover property (RX_TERMINATE_O && !MOD_OOK_I);
endmodule
bind fdc_top fdc_top_asserts u_fdc_top_asserts (.*);
`default_nettype wire

// File: testbench/fdc_host.sv
// Host controller model driving the register port.
// Assumes one caller at a time.
`timescale 1ns/10ps
`default_nettype none
module fdc_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output var  logic [5:0] addr_o,
  output var  logic       we_o,
  output var  logic       re_o,
  output var  logic [7:0] wdata_o
);
  // ==========
  initial {addr_o, we_o, re_o, wdata_o} = 16'h0000;
  // One-edge strobe; data inverted after release so stale data never looks valid
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk_i) #1;
    {addr_o, we_o, re_o, wdata_o} = {a, w, !w, d};
    @(posedge clk_i) #1;
    {we_o, re_o, wdata_o} = {2'b00, ~d};
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

// File: testbench/fdc_top_bench.sv
// Self-checking bench: register table, then transmit and termination cases.
// Assumes the host model is the only register port driver.
`timescale 1ns/10ps
`default_nettype none
module fdc_top_bench;
  import fdc_pkg::*;
  typedef struct packed {logic [5:0] a; logic [7:0] w, r; logic [10:0] d; logic [3:0] t;} fdc_row_t;
  logic clk = 0, rst = 1, we, re, ook = 0, txa = 0, sym = 0, rxa = 0, tick = 0, cs = 0, term;
  logic [5:0]         addr;
  logic [7:0]         wd, rd, q;
  logic [3:0]         tune;
  logic [10:0]        dev;
  logic signed [11:0] offs;
  int                 n_fail = 0, cmp_count = 0;
  fdc_row_t rows [6] = '{'{6'h15, 8'hFF, 8'h77, 11'h780, 4'h7}, '{6'h15, 8'h08, 8'h00, 11'h008, 4'h7},
    '{6'h16, 8'hFF, 8'h1F, 11'h008, 4'hF}, '{6'h16, 8'hE5, 8'h05, 11'h008, 4'h5},
    '{6'h15, 8'h23, 8'h23, 11'h02C, 4'h5}, '{6'h16, 8'h17, 8'h17, 11'h02C, 4'h7}};
  // ==========
  always #20 clk = ~clk;
  fdc_host u_fdc_host (.clk_i(clk), .rdata_i(rd), .addr_o(addr), .we_o(we), .re_o(re),
    .wdata_o(wd));
  fdc_top u_fdc_top (.CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WE_I(we), .REG_RE_I(re),
    .REG_WDATA_I(wd), .REG_RDATA_O(rd), .MOD_OOK_I(ook), .TX_ACTIVE_I(txa), .TX_SYMBOL_I(sym),
    .TX_FREQ_OFFSET_O(offs), .RX_ACTIVE_I(rxa), .SYMBOL_TICK_I(tick), .CARRIER_SENSE_I(cs),
    .RX_EXPECTED_DEV_O(dev), .RX_TERMINATE_O(term), .TUNE_O(tune));
  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk) #1;
  endtask
  // Bounded wait; running out is counted by the compare
  task automatic pulse_within(input int n);
    for (int i = 0; i < n && term !== 1'b1; i++) cyc(1);
    chk(term, 1'b1);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    cyc(10);
    rst = 0;
    u_fdc_host.acc(0, FDC_DEV_OFFSET, 8'h00, q);
    chk(q, 8'h47);
    chk(dev, 11'h0F0);
    u_fdc_host.acc(0, FDC_SMC2_OFFSET, 8'h00, q);
    chk(q, 8'h07);
    u_fdc_host.acc(0, 6'h3F, 8'h00, q);
    chk(q, 8'h00);
    foreach (rows[i]) begin
      u_fdc_host.acc(1, rows[i].a, rows[i].w, q);
      u_fdc_host.acc(0, rows[i].a, 8'h00, q);
      chk(q, rows[i].r);
      chk(dev, rows[i].d);
      chk(tune, rows[i].t);
    end
    txa = 1;
    cyc(2);
    chk(offs, 12'hFD4);
    sym = 1;
    cyc(2);
    chk(offs, 12'h02C);
    ook = 1;
    cyc(2);
    chk(offs, 12'h000);
    chk(dev, 11'h000);
    txa = 0;
    rxa = 1;
    cyc(1);
    tick = 1;
    repeat (7) begin
      cyc(1);
      chk(term, 1'b0);
    end
    cyc(1);
    pulse_within(3);
    rxa = 0;
    cyc(2);
    rxa = 1;
    cs = 1;
    cyc(2);
    cs = 0;
    repeat (10) begin
      cyc(1);
      chk(term, 1'b0);
    end
    {rxa, tick, ook} = 3'b000;
    cyc(2);
    rxa = 1;
    cyc(2);
    cs = 1;
    cyc(2);
    cs = 0;
    pulse_within(3);
    rst = 1;
    cyc(2);
    rst = 0;
    chk(tune, 4'h7);
    u_fdc_host.acc(0, FDC_DEV_OFFSET, 8'h00, q);
    chk(q, 8'h47);
    u_fdc_host.acc(0, FDC_SMC2_OFFSET, 8'h00, q);
    chk(q, 8'h07);
    end_sim();
  end
endmodule
`default_nettype wire
